// ===== gcd_pkg.sv
// Package for the guarded compare, copy and halfword dot-product datapath.
// Assumes one core clock; operation codes are those of the issue logic.
package gcd_pkg;
	localparam int unsigned gcd_data_w = 32;
	localparam int unsigned gcd_opc_w = 8;
	localparam int unsigned gcd_imm_w = 7;
	localparam int unsigned gcd_reg_w = 7;
	localparam int unsigned gcd_slot_w = 3;
	// Operation codes
	localparam logic [7:0] gcd_opc_copy = 8'h0c;
	localparam logic [7:0] gcd_opc_eql = 8'h25;
	localparam logic [7:0] gcd_opc_eqli = 8'h04;
	localparam logic [7:0] gcd_opc_dot = 8'h5d;
	// Latencies in cycles
	localparam int unsigned gcd_alu_lat = 1;
	localparam int unsigned gcd_dot_lat = 3;
	// Slot limits
	localparam logic [2:0] gcd_alu_slot_lo = 3'h1;
	localparam logic [2:0] gcd_alu_slot_hi = 3'h5;
	localparam logic [2:0] gcd_dot_slot_lo = 3'h2;
	localparam logic [2:0] gcd_dot_slot_hi = 3'h3;
	// Saturation bounds and zero register
	localparam logic [31:0] gcd_sat_min = 32'h80000000;
	localparam logic [31:0] gcd_sat_max = 32'h7fffffff;
	localparam logic [31:0] gcd_zero_value = 32'h00000000;
	localparam logic [6:0] gcd_zero_register = 7'h00;
endpackage

// ===== gcd_datapath.sv
// Guarded copy, compare-equal, compare-equal-immediate and dot-product unit.
// Assumes issue logic presents one operation per cycle with operands read.
// How it works
// - Guard bit 0 gates the write; unguarded operations write unless refused for their slot.
// - Copy passes first source unchanged to destination under guard.
// - Copy is zero register plus source; zero register reads zero.
// - Copy and compares take one cycle, issue in slots one to five.
// - Compare-equal writes one when 32-bit sources match, else zero.
// - Compare-immediate writes one when source equals the sign-extended modifier.
// - Dot product multiplies matching signed halves and adds products.
// - Products and sum at full precision, then saturate to 32 bits.
// - Dot product takes three cycles, issues only in slots two or three.
`timescale 1ns/100ps
module gcd_datapath
	import gcd_pkg::*;
#(
	parameter int unsigned data_w = gcd_data_w
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic issue_valid,
	input wire logic [gcd_pkg::gcd_opc_w-1:0] issue_opcode,
	input wire logic [gcd_pkg::gcd_slot_w-1:0] issue_slot,
	input wire logic [gcd_pkg::gcd_data_w-1:0] first_source,
	input wire logic [gcd_pkg::gcd_data_w-1:0] second_source,
	input wire logic [gcd_pkg::gcd_imm_w-1:0] issue_modifier,
	input wire logic guard_present,
	input wire logic [gcd_pkg::gcd_data_w-1:0] guard_value,
	input wire logic [gcd_pkg::gcd_reg_w-1:0] issue_dest,
	output logic issue_refused,
	output logic alu_wr_en,
	output logic [gcd_pkg::gcd_reg_w-1:0] alu_wr_dest,
	output logic [gcd_pkg::gcd_data_w-1:0] alu_wr_data,
	output logic dot_wr_en,
	output logic [gcd_pkg::gcd_reg_w-1:0] dot_wr_dest,
	output logic [gcd_pkg::gcd_data_w-1:0] dot_wr_data
);
	import gcd_pkg::*;

	if (data_w != gcd_data_w) begin : g_width_check
		$error("gcd_datapath supports only 32-bit data");
	end

	wire logic guard_ok = !guard_present || guard_value[0];
	wire logic is_copy = issue_opcode == gcd_opc_copy;
	wire logic is_eql = issue_opcode == gcd_opc_eql;
	wire logic is_eqli = issue_opcode == gcd_opc_eqli;
	wire logic is_dot = issue_opcode == gcd_opc_dot;
	wire logic is_alu_op = is_copy || is_eql || is_eqli;
	wire logic alu_slot_ok = issue_slot >= gcd_alu_slot_lo && issue_slot <= gcd_alu_slot_hi;
	wire logic dot_slot_ok = issue_slot >= gcd_dot_slot_lo && issue_slot <= gcd_dot_slot_hi;
	wire logic alu_go = issue_valid && is_alu_op && alu_slot_ok;
	wire logic dot_go = issue_valid && is_dot && dot_slot_ok;
	assign issue_refused = issue_valid && !alu_go && !dot_go;

	// Copy through the adder with the zero register as first operand
	wire logic [31:0] zero_operand = gcd_zero_value;
	wire logic [31:0] copy_result = 32'(zero_operand + first_source);
	wire logic [31:0] imm_ext = {{25{issue_modifier[6]}}, issue_modifier};
	wire logic eql_hit = $signed(first_source) == $signed(second_source);
	wire logic eqli_hit = $signed(first_source) == $signed(imm_ext);
	wire logic [31:0] alu_result = is_copy ? copy_result :
		{31'h0, (is_eql ? eql_hit : eqli_hit)};

	always_ff @(posedge clk) begin
		if (reset) begin
			alu_wr_en <= 1'b0;
			alu_wr_dest <= '0;
			alu_wr_data <= '0;
		end else begin
			alu_wr_en <= alu_go && guard_ok;
			alu_wr_dest <= issue_dest;
			alu_wr_data <= alu_result;
		end
	end

	// Stage 1: halfword products at full precision
	logic signed [31:0] prod_hi_q, prod_lo_q;
	logic signed [33:0] sum_q;
	logic dot_v1_q, dot_v2_q;
	logic [gcd_reg_w-1:0] dest1_q, dest2_q;
	wire logic signed [31:0] prod_hi_d = $signed(first_source[31:16]) * $signed(second_source[31:16]);
	wire logic signed [31:0] prod_lo_d = $signed(first_source[15:0]) * $signed(second_source[15:0]);
	wire logic signed [33:0] sum_d = 34'(34'(prod_hi_q) + 34'(prod_lo_q));
	wire logic [31:0] sat_d = (sum_q > $signed(34'(signed'(gcd_sat_max)))) ? gcd_sat_max :
		(sum_q < $signed(34'(signed'(gcd_sat_min)))) ? gcd_sat_min : sum_q[31:0];

	always_ff @(posedge clk) begin
		if (reset) begin
			dot_v1_q <= 1'b0;
			prod_hi_q <= '0;
			prod_lo_q <= '0;
			dest1_q <= '0;
		end else begin
			dot_v1_q <= dot_go && guard_ok;
			prod_hi_q <= prod_hi_d;
			prod_lo_q <= prod_lo_d;
			dest1_q <= issue_dest;
		end
	end

	// Stage 2: sum of the two products
	always_ff @(posedge clk) begin
		if (reset) begin
			dot_v2_q <= 1'b0;
			sum_q <= '0;
			dest2_q <= '0;
		end else begin
			dot_v2_q <= dot_v1_q;
			sum_q <= sum_d;
			dest2_q <= dest1_q;
		end
	end

	// Stage 3: saturated result to the write port
	always_ff @(posedge clk) begin
		if (reset) begin
			dot_wr_en <= 1'b0;
			dot_wr_dest <= '0;
			dot_wr_data <= '0;
		end else begin
			dot_wr_en <= dot_v2_q;
			dot_wr_dest <= dest2_q;
			dot_wr_data <= sat_d;
		end
	end

	chk_guard_blocks_alu: assert property (@(posedge clk) disable iff (reset)
		issue_valid && is_alu_op && guard_present && !guard_value[0] |=> !alu_wr_en)
		else $error("guarded-off alu op wrote");

	chk_alu_unguarded: assert property (@(posedge clk) disable iff (reset)
		alu_go && !guard_present |=> alu_wr_en)
		else $error("unguarded alu op did not write");

	chk_guard_blocks_dot: assert property (@(posedge clk) disable iff (reset)
		issue_valid && is_dot && guard_present && !guard_value[0] |-> ##3 !dot_wr_en)
		else $error("guarded-off dot product wrote");

	chk_dot_unguarded: assert property (@(posedge clk) disable iff (reset)
		dot_go && !guard_present |-> ##3 dot_wr_en)
		else $error("unguarded dot product did not write");

	chk_copy_value: assert property (@(posedge clk) disable iff (reset)
		alu_go && guard_ok && is_copy |=> alu_wr_en && alu_wr_data == $past(first_source))
		else $error("copy result wrong");

	chk_copy_guard_off: assert property (@(posedge clk) disable iff (reset)
		alu_go && is_copy && guard_present && !guard_value[0] |=> !alu_wr_en)
		else $error("guarded-off copy wrote");

	chk_copy_zero: assert property (@(posedge clk) disable iff (reset)
		alu_go && guard_ok && is_copy && first_source == gcd_zero_value |=> alu_wr_data == gcd_zero_value)
		else $error("copy of zero wrong");

	chk_alu_one_cycle: assert property (@(posedge clk) disable iff (reset)
		alu_go && guard_ok |=> alu_wr_en && alu_wr_dest == $past(issue_dest))
		else $error("alu result not after one cycle");

	chk_alu_bad_slot: assert property (@(posedge clk) disable iff (reset)
		issue_valid && is_alu_op && !alu_slot_ok |-> issue_refused)
		else $error("alu op in bad slot not refused");

	chk_refused_no_alu: assert property (@(posedge clk) disable iff (reset)
		issue_refused |=> !alu_wr_en)
		else $error("refused op wrote alu result");

	chk_good_not_refused: assert property (@(posedge clk) disable iff (reset)
		alu_go || dot_go |-> !issue_refused)
		else $error("legal op refused");

	chk_eql_value: assert property (@(posedge clk) disable iff (reset)
		alu_go && guard_ok && is_eql |=> alu_wr_data == {31'h0, $past(first_source == second_source)})
		else $error("compare-equal result wrong");

	chk_eql_signed_min: assert property (@(posedge clk) disable iff (reset)
		alu_go && guard_ok && is_eql && first_source == 32'h80000000 && second_source == 32'h80000000
		|=> alu_wr_data == 32'h00000001)
		else $error("compare-equal of most negative wrong");

	chk_eqli_value: assert property (@(posedge clk) disable iff (reset)
		alu_go && guard_ok && is_eqli |=>
		alu_wr_data[0] == ($past(first_source) == 32'($signed($past(issue_modifier)))))
		else $error("compare-immediate result wrong");

	chk_eqli_one_bit: assert property (@(posedge clk) disable iff (reset)
		alu_go && guard_ok && is_eqli |=> alu_wr_data[31:1] == 31'h0)
		else $error("compare-immediate upper bits set");

	chk_dot_small: assert property (@(posedge clk) disable iff (reset)
		dot_go && first_source == 32'h00020003 && second_source == 32'h00010002
		|-> ##3 dot_wr_data == 32'h00000008)
		else $error("dot product value wrong");

	chk_dot_sat: assert property (@(posedge clk) disable iff (reset)
		dot_go && first_source == 32'h80008000 && second_source == 32'h80008000
		|-> ##3 dot_wr_data == gcd_sat_max)
		else $error("dot product saturation wrong");

	chk_dot_three: assert property (@(posedge clk) disable iff (reset)
		dot_go && guard_ok |-> ##3 dot_wr_en && dot_wr_dest == $past(issue_dest, 3))
		else $error("dot product not after three cycles");

	chk_dot_bad_slot: assert property (@(posedge clk) disable iff (reset)
		issue_valid && is_dot && !dot_slot_ok |-> issue_refused)
		else $error("dot product in bad slot not refused");

	chk_refused_no_dot: assert property (@(posedge clk) disable iff (reset)
		issue_refused |-> ##3 !dot_wr_en)
		else $error("refused op wrote dot result");

	chk_dot_guard: assert property (@(posedge clk) disable iff (reset)
		!(dot_go && guard_ok) |-> ##3 !dot_wr_en)
		else $error("suppressed dot product wrote");

	chk_alu_quiet: assert property (@(posedge clk) disable iff (reset)
		!(alu_go && guard_ok) |=> !alu_wr_en)
		else $error("suppressed alu op wrote");

	chk_dot_back_to_back: assert property (@(posedge clk) disable iff (reset)
		dot_go && guard_ok && $past(dot_go && guard_ok) |-> ##3 dot_wr_en && $past(dot_wr_en))
		else $error("back to back dot products lost");
endmodule // gcd_datapath

// ===== gcd_regfile_model.sv
// Register file model on the write side of the datapath.
// Assumes writes land on the rising clock edge.
`timescale 1ns/100ps
module gcd_regfile_model (
	input wire logic clk,
	input wire logic alu_wr_en,
	input wire logic [6:0] alu_wr_dest,
	input wire logic [31:0] alu_wr_data,
	input wire logic dot_wr_en,
	input wire logic [6:0] dot_wr_dest,
	input wire logic [31:0] dot_wr_data
);
	logic [31:0] rf_q [128];
	initial begin
		foreach (rf_q[i]) rf_q[i] = 32'h5a5a5a5a;
	end
	always @(posedge clk) begin
		if (alu_wr_en) rf_q[alu_wr_dest] <= alu_wr_data;
		if (dot_wr_en) rf_q[dot_wr_dest] <= dot_wr_data;
	end
endmodule // gcd_regfile_model

// ===== tb_top.sv
// Self-checking bench for the guarded datapath.
// Assumes one 50 MHz clock and the register file model.
`timescale 1ns/100ps
module tb_top;
	import gcd_pkg::*;
	logic clk = 1'b0, reset = 1'b1, iv = 1'b0, gp = 1'b0, rf, ae, de;
	logic [7:0] opc = 8'h00;
	logic [2:0] sl = 3'h1;
	logic [31:0] a = 32'h0, b = 32'h0, g = 32'h0, ad, dd;
	logic [6:0] m = 7'h00, dst = 7'h01, aw, dw;
	int err_count = 0, tests_run = 0;
	always #10 clk = ~clk;
	gcd_datapath DUT (.clk(clk), .reset(reset), .issue_valid(iv), .issue_opcode(opc),
		.issue_slot(sl), .first_source(a), .second_source(b), .issue_modifier(m),
		.guard_present(gp), .guard_value(g), .issue_dest(dst), .issue_refused(rf),
		.alu_wr_en(ae), .alu_wr_dest(aw), .alu_wr_data(ad), .dot_wr_en(de),
		.dot_wr_dest(dw), .dot_wr_data(dd));
	gcd_regfile_model p (.clk(clk), .alu_wr_en(ae), .alu_wr_dest(aw), .alu_wr_data(ad),
		.dot_wr_en(de), .dot_wr_dest(dw), .dot_wr_data(dd));
	task cmp(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask
	// Guard code: 0 none, 2 false, 3 true
	task op(input logic [7:0] o, input logic [2:0] s, input logic [31:0] x, input logic [31:0] y,
		input logic [6:0] n, input logic [1:0] gd, input logic bad, input logic [31:0] e);
		int lat;
		logic wr;
		lat = (o == gcd_opc_dot) ? 3 : 1;
		wr = !bad && (gd != 2'h2);
		opc = o;
		sl = s;
		a = x;
		b = y;
		m = n;
		gp = gd[1];
		g = {31'h0, gd[0]};
		iv = 1'b1;
		#1 cmp({31'h0, rf}, {31'h0, bad});
		@(negedge clk) iv = 1'b0;
		for (int k = 1; k <= 3; k++) begin
			cmp({31'h0, (lat == 1) ? ae : de}, {31'h0, wr && (k == lat)});
			@(negedge clk);
		end
		cmp(p.rf_q[dst], wr ? e : 32'h5a5a5a5a);
		dst = dst + 7'h01;
	endtask
	task t_copy;
		op(gcd_opc_copy, 3'h1, 32'h100, 32'hffffffff, 7'h00, 2'h0, 1'b0, 32'h100);
		op(gcd_opc_copy, 3'h5, 32'h12345678, 32'h1, 7'h00, 2'h2, 1'b0, 32'h0);
		op(gcd_opc_copy, 3'h3, 32'h12345678, 32'h7, 7'h00, 2'h3, 1'b0, 32'h12345678);
		op(gcd_opc_copy, 3'h2, 32'h0, 32'h9, 7'h00, 2'h0, 1'b0, 32'h0);
		$display("copy done");
	endtask
	task t_eql;
		op(gcd_opc_eql, 3'h2, 32'h3, 32'h4, 7'h00, 2'h0, 1'b0, 32'h0);
		op(gcd_opc_eql, 3'h4, 32'h1000, 32'h1000, 7'h00, 2'h3, 1'b0, 32'h1);
		op(gcd_opc_eql, 3'h1, 32'h80000000, 32'h4, 7'h00, 2'h0, 1'b0, 32'h0);
		op(gcd_opc_eql, 3'h3, 32'h80000000, 32'h80000000, 7'h00, 2'h0, 1'b0, 32'h1);
		op(gcd_opc_eqli, 3'h5, 32'h3, 32'h0, 7'h03, 2'h0, 1'b0, 32'h1);
		op(gcd_opc_eqli, 3'h1, 32'h100, 32'h0, 7'h3f, 2'h3, 1'b0, 32'h0);
		op(gcd_opc_eqli, 3'h2, 32'hffffffc0, 32'h0, 7'h40, 2'h0, 1'b0, 32'h1);
		op(gcd_opc_eqli, 3'h3, 32'h40, 32'h0, 7'h40, 2'h0, 1'b0, 32'h0);
		$display("compare done");
	endtask
	task t_dot;
		op(gcd_opc_dot, 3'h2, 32'h00020003, 32'h00010002, 7'h00, 2'h0, 1'b0, 32'h8);
		op(gcd_opc_dot, 3'h3, 32'hff9c0064, 32'h0064ff9c, 7'h00, 2'h2, 1'b0, 32'h0);
		op(gcd_opc_dot, 3'h3, 32'hff9c0064, 32'h0064ff9c, 7'h00, 2'h3, 1'b0, 32'hffffb1e0);
		op(gcd_opc_dot, 3'h2, 32'h80008000, 32'h80008000, 7'h00, 2'h0, 1'b0, 32'h7fffffff);
		$display("dot done");
	endtask
	task t_slot;
		op(gcd_opc_dot, 3'h1, 32'h1, 32'h1, 7'h00, 2'h0, 1'b1, 32'h0);
		op(gcd_opc_dot, 3'h4, 32'h1, 32'h1, 7'h00, 2'h0, 1'b1, 32'h0);
		op(gcd_opc_eql, 3'h6, 32'h1, 32'h1, 7'h00, 2'h0, 1'b1, 32'h0);
		op(gcd_opc_eql, 3'h0, 32'h1, 32'h1, 7'h00, 2'h0, 1'b1, 32'h0);
		$display("slot done");
	endtask
	task t_back;
		opc = gcd_opc_dot;
		sl = 3'h2;
		gp = 1'b0;
		a = 32'h00020003;
		b = 32'h00010002;
		iv = 1'b1;
		@(negedge clk) a = 32'hff9c0064;
		b = 32'h0064ff9c;
		sl = 3'h3;
		dst = dst + 7'h01;
		@(negedge clk) iv = 1'b0;
		@(negedge clk);
		cmp({31'h0, de}, 32'h1);
		@(negedge clk);
		cmp({31'h0, de}, 32'h1);
		@(negedge clk);
		cmp(p.rf_q[dst - 7'h01], 32'h8);
		cmp(p.rf_q[dst], 32'hffffb1e0);
		dst = dst + 7'h01;
		$display("back to back done");
	endtask
	task test_done;
		$display("checks %0d errors %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		repeat (4) @(negedge clk);
		reset = 1'b0;
		t_copy();
		t_eql();
		t_dot();
		t_slot();
		t_back();
		test_done();
	end
endmodule // tb_top
